/* File: core/charger_ctrl.sv */
// Charger control logic: stage machine, protection, status pin, control pin.
// Assumes comparator inputs are synchronous, debounced levels from analog.
// Summary of operation
// - When enabled, battery below precharge threshold selects precharge, else fast.
// - Precharge drives fixed precharge current and pulls status output low.
// - Above precharge threshold, enter constant-current fast charge.
// - At overcharge threshold release status and regulate to float voltage.
// - After completion stay enabled and keep regulating at float voltage.
// - Below recharge threshold restart charge, status low during recharge.
// - Over-voltage longer than deglitch disables regulator and charging.
// - Over-voltage at power-up shuts down after deglitch until input falls.
// - Under lockout: ignore control pin, regulator and charging off, status released.
// - Thermistor outside window suspends charging, resumes on return.
// - Thermistor fault while charging flashes status with fixed period, half duty.
// - Regulator on above undervoltage threshold until over-voltage has lasted past deglitch.
// - With no input, status held low turns thermistor sensing off.
// - Control low past deglitch enters wait window accepting pulses.
// - End of wait starts up; no command keeps the last latched limit, default after reset.
// - Pin low for latch interval hands pulse count to decode.
// - Counts four to eleven select eight limits; others leave unchanged.
// - Control pin high longer than latch interval disables the device.
`timescale 1ns/1ns
module charger_ctrl (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Comparator inputs
    input  wire logic       in_above_uvlo,
    input  wire logic       in_above_ovp,
    input  wire logic       bat_above_precharge,
    input  wire logic       bat_at_overcharge,
    input  wire logic       bat_below_recharge,
    input  wire logic       ts_in_window,
    // Control pin and status pin
    input  wire logic       ctrl_pin,
    input  wire logic       status_pin_in,
    output logic            charge_status_out,
    output logic            charge_status_oe_n,
    // Power stage controls
    output logic            aux_regulator_en,
    output logic            charge_en,
    output logic            precharge_mode,
    output logic            float_regulation,
    output logic            thermistor_sense_en,
    output logic [3:0]      input_limit_sel
);
    import charger_pkg::*;

    logic                 ovp_q;
    logic [CNT_W-1:0]     ovp_cnt_q;
    if_state_t            if_state_q;
    logic [CNT_W-1:0]     if_cnt_q;
    logic [CNT_W-1:0]     high_cnt_q;
    logic [3:0]           limit_q;
    chg_state_t           chg_state_q;
    logic [CNT_W-1:0]     flash_cnt_q;
    logic                 flash_q;
    logic                 ts_en_q;
    logic                 latch_pulse;
    logic [PULSE_W-1:0]   pulse_count;
    logic                 powered;
    logic                 running;
    logic                 listen;
    logic                 charging;
    logic [4:0]           decoded_limit;

    function automatic logic [4:0] decode_limit(input logic [PULSE_W-1:0] n);
        logic [4:0] r;
        r = 5'h00;
        if (n >= PULSE_FIRST && n <= PULSE_LAST) begin
            r = {1'b1, 4'(n - PULSE_FIRST)};
        end
        return r;
    endfunction

    assign powered = in_above_uvlo && !ovp_q;
    assign running = powered && if_state_q == IF_RUN;
    assign listen  = powered && (if_state_q == IF_WAIT ||
                                 if_state_q == IF_RUN);

    pulse_decoder i_pulse_decoder (
        .clk         (clk),
        .rst         (rst),
        .listen      (listen),
        .ctrl_pin    (ctrl_pin),
        .latch_pulse (latch_pulse),
        .pulse_count (pulse_count)
    );

    always_ff @(posedge clk) begin
        if (rst || !in_above_ovp || !in_above_uvlo) begin
            ovp_cnt_q <= '0;
            ovp_q     <= 1'b0;
        end else if (ovp_cnt_q == CNT_W'(OVP_DGL_CYC - 1)) begin
            ovp_q <= 1'b1;
        end else begin
            ovp_cnt_q <= ovp_cnt_q + 21'h000001;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || !ctrl_pin || !powered) begin
            high_cnt_q <= '0;
        end else if (high_cnt_q != CNT_W'(LATCH_CYC)) begin
            high_cnt_q <= high_cnt_q + 21'h000001;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || !powered) begin
            if_state_q <= IF_OFF;
            if_cnt_q   <= '0;
        end else if (high_cnt_q == CNT_W'(LATCH_CYC)) begin
            if_state_q <= IF_OFF;
            if_cnt_q   <= '0;
        end else begin
            case (if_state_q)
                IF_OFF: begin
                    if (!ctrl_pin) begin
                        if_state_q <= IF_DGL;
                        if_cnt_q   <= '0;
                    end
                end
                IF_DGL: begin
                    if (ctrl_pin) begin
                        if_state_q <= IF_OFF;
                    end else if (if_cnt_q == CNT_W'(CTRL_DGL_CYC - 1)) begin
                        if_state_q <= IF_WAIT;
                        if_cnt_q   <= '0;
                    end else begin
                        if_cnt_q <= if_cnt_q + 21'h000001;
                    end
                end
                IF_WAIT: begin
                    if (if_cnt_q == CNT_W'(WAIT_CYC - 1)) begin
                        if_state_q <= IF_RUN;
                        if_cnt_q   <= '0;
                    end else begin
                        if_cnt_q <= if_cnt_q + 21'h000001;
                    end
                end
                default: begin
                    if_state_q <= IF_RUN;
                end
            endcase
        end
    end

    assign decoded_limit = decode_limit(pulse_count);
    always_ff @(posedge clk) begin
        if (rst) begin
            limit_q <= LIMIT_DEFAULT;
        end else if (latch_pulse && decoded_limit[4]) begin
            limit_q <= decoded_limit[3:0];
        end
    end

    always_ff @(posedge clk) begin
        if (rst || !running) begin
            chg_state_q <= CHG_IDLE;
        end else begin
            case (chg_state_q)
                CHG_IDLE: begin
                    chg_state_q <= bat_above_precharge ? CHG_FAST : CHG_PRE;
                end
                CHG_PRE: begin
                    if (bat_above_precharge) begin
                        chg_state_q <= CHG_FAST;
                    end
                end
                CHG_FAST, CHG_RECHARGE: begin
                    if (bat_at_overcharge) begin
                        chg_state_q <= CHG_DONE;
                    end
                end
                default: begin
                    if (bat_below_recharge) begin
                        chg_state_q <= CHG_RECHARGE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst || ts_in_window) begin
            flash_cnt_q <= '0;
            flash_q     <= 1'b0;
        end else if (flash_cnt_q == CNT_W'(FLASH_HALF_CYC - 1)) begin
            flash_cnt_q <= '0;
            flash_q     <= !flash_q;
        end else begin
            flash_cnt_q <= flash_cnt_q + 21'h000001;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ts_en_q <= 1'b1;
        end else if (in_above_uvlo) begin
            ts_en_q <= 1'b1;
        end else begin
            ts_en_q <= status_pin_in;
        end
    end

    assign charging = chg_state_q == CHG_PRE || chg_state_q == CHG_FAST ||
                      chg_state_q == CHG_RECHARGE;

    assign aux_regulator_en = powered;
    assign charge_en        = running && chg_state_q != CHG_IDLE &&
                              ts_in_window;
    assign precharge_mode   = chg_state_q == CHG_PRE;
    assign float_regulation = chg_state_q == CHG_DONE;
    assign input_limit_sel  = limit_q;
    assign thermistor_sense_en = ts_en_q;
    // Only the low level is driven; a released pin is pulled up outside.
    assign charge_status_out  = 1'b0;
    assign charge_status_oe_n = !(charging &&
                                  (ts_in_window || !flash_q));

    chk_regulator_window: assert property (@(posedge clk)
        disable iff (rst) in_above_uvlo && !$past(in_above_ovp)
        |-> aux_regulator_en)
        else $error("regulator off inside input window");

    sequence ovp_held_s;
        (in_above_ovp && in_above_uvlo) [*2];
    endsequence

    chk_ovp_glitch: assert property (@(posedge clk) disable iff (rst)
        $rose(in_above_ovp) && in_above_uvlo |-> !ovp_q [*3])
        else $error("over-voltage acted before deglitch");

    chk_ovp_trip: assert property (@(posedge clk) disable iff (rst)
        ovp_cnt_q == CNT_W'(OVP_DGL_CYC - 2) ##0 ovp_held_s
        |=> ovp_q && !aux_regulator_en && !charge_en)
        else $error("over-voltage held past deglitch not acted on");

    chk_ovp_release: assert property (@(posedge clk) disable iff (rst)
        ovp_q && !in_above_ovp |=> !ovp_q && aux_regulator_en == in_above_uvlo)
        else $error("over-voltage not released after input fell");

    chk_uvlo_off: assert property (@(posedge clk) disable iff (rst)
        !in_above_uvlo |-> (!charge_en && !aux_regulator_en)
        ##1 charge_status_oe_n)
        else $error("outputs active under lockout");

    chk_ts_suspend: assert property (@(posedge clk) disable iff (rst)
        !ts_in_window |-> !charge_en)
        else $error("charging while thermistor outside window");

    chk_done_release: assert property (@(posedge clk) disable iff (rst)
        chg_state_q == CHG_FAST && bat_at_overcharge && running
        |=> float_regulation && charge_status_oe_n)
        else $error("status not released at overcharge");

    chk_recharge_low: assert property (@(posedge clk) disable iff (rst)
        chg_state_q == CHG_DONE && bat_below_recharge && running &&
        !bat_at_overcharge && ts_in_window
        |=> chg_state_q == CHG_RECHARGE && !charge_status_oe_n)
        else $error("recharge did not restart with status low");

    chk_stage_select: assert property (@(posedge clk) disable iff (rst)
        chg_state_q == CHG_IDLE && running && !bat_above_precharge
        |=> precharge_mode && (!charge_status_oe_n || !ts_in_window))
        else $error("precharge not selected below threshold");

    chk_long_high: assert property (@(posedge clk) disable iff (rst)
        high_cnt_q == CNT_W'(LATCH_CYC) |=> if_state_q == IF_OFF)
        else $error("long control high did not disable");

    chk_limit_hold: assert property (@(posedge clk) disable iff (rst)
        latch_pulse && (pulse_count < PULSE_FIRST || pulse_count > PULSE_LAST)
        |=> $stable(limit_q))
        else $error("limit changed on unmapped count");

    chk_flash_toggle: assert property (@(posedge clk) disable iff (rst)
        !ts_in_window && flash_cnt_q == CNT_W'(FLASH_HALF_CYC - 1)
        |=> flash_q != $past(flash_q))
        else $error("fault flash did not toggle at half period");

    chk_flash_start: assert property (@(posedge clk) disable iff (rst)
        $fell(ts_in_window) |=> !flash_q)
        else $error("fault flash did not start in the low half");

    chk_wait_entry: assert property (@(posedge clk) disable iff (rst)
        if_state_q == IF_DGL && powered && !ctrl_pin &&
        if_cnt_q == CNT_W'(CTRL_DGL_CYC - 1) |=> if_state_q == IF_WAIT)
        else $error("wait window not entered after deglitch");

    chk_run_start: assert property (@(posedge clk) disable iff (rst)
        if_state_q == IF_WAIT && powered && if_cnt_q == CNT_W'(WAIT_CYC - 1)
        && high_cnt_q != CNT_W'(LATCH_CYC) |=> if_state_q == IF_RUN)
        else $error("device did not start up at end of wait");

    chk_limit_steady: assert property (@(posedge clk) disable iff (rst)
        !latch_pulse |=> $stable(limit_q))
        else $error("limit changed without a decode");

    chk_fast_entry: assert property (@(posedge clk) disable iff (rst)
        chg_state_q == CHG_PRE && bat_above_precharge && running
        |=> chg_state_q == CHG_FAST && !precharge_mode)
        else $error("fast charge not entered above threshold");

    chk_done_float: assert property (@(posedge clk) disable iff (rst)
        chg_state_q == CHG_DONE && running && ts_in_window
        |-> charge_en && float_regulation)
        else $error("charger not regulating at float after completion");

    chk_sense_off: assert property (@(posedge clk) disable iff (rst)
        !in_above_uvlo && !status_pin_in |=> !thermistor_sense_en)
        else $error("thermistor sense left on with status held low");
endmodule

/* File: shared/charger_pkg.sv */
// Package for the charger control logic: timing counts, limits and states.
// Assumes a single 25 MHz clock; analog thresholds arrive as comparator bits.
package charger_pkg;
    localparam int unsigned CLK_MHZ       = 25;
    localparam int unsigned OVP_DGL_US    = 115;
    localparam int unsigned CTRL_DGL_US   = 50;
    localparam int unsigned WAIT_MS       = 32;
    localparam int unsigned LATCH_MS      = 2;
    localparam int unsigned FLASH_MS      = 100;
    localparam int unsigned OVP_DGL_CYC   = OVP_DGL_US * CLK_MHZ;
    localparam int unsigned CTRL_DGL_CYC  = CTRL_DGL_US * CLK_MHZ;
    localparam int unsigned WAIT_CYC      = WAIT_MS * 1000 * CLK_MHZ;
    localparam int unsigned LATCH_CYC     = LATCH_MS * 1000 * CLK_MHZ;
    localparam int unsigned FLASH_HALF_CYC = FLASH_MS * 500 * CLK_MHZ;
    localparam int unsigned CNT_W         = 21;
    localparam int unsigned PULSE_W       = 5;
    localparam int unsigned PULSE_MAX     = 16;
    localparam logic [3:0]  LIMIT_DEFAULT = 4'h8;
    localparam logic [3:0]  LIMIT_93MA    = 4'h0;
    localparam logic [3:0]  LIMIT_187MA   = 4'h1;
    localparam logic [3:0]  LIMIT_280MA   = 4'h2;
    localparam logic [3:0]  LIMIT_374MA   = 4'h3;
    localparam logic [3:0]  LIMIT_467MA   = 4'h4;
    localparam logic [3:0]  LIMIT_654MA   = 4'h5;
    localparam logic [3:0]  LIMIT_794MA   = 4'h6;
    localparam logic [3:0]  LIMIT_935MA   = 4'h7;
    localparam logic [PULSE_W-1:0] PULSE_FIRST = 5'h04;
    localparam logic [PULSE_W-1:0] PULSE_LAST  = 5'h0b;

    typedef enum logic [2:0] {
        CHG_IDLE,
        CHG_PRE,
        CHG_FAST,
        CHG_DONE,
        CHG_RECHARGE
    } chg_state_t;

    typedef enum logic [2:0] {
        IF_OFF,
        IF_DGL,
        IF_WAIT,
        IF_RUN
    } if_state_t;
endpackage

/* File: core/pulse_decoder.sv */
// Pulse counter and decoder for the single-wire control pin.
// Assumes the pin is synchronous to clk and its level already clean.
`timescale 1ns/1ns
module pulse_decoder (
    // Clock and reset
    input  wire logic                        clk,
    input  wire logic                        rst,
    // Control
    input  wire logic                        listen,
    input  wire logic                        ctrl_pin,
    // Result
    output logic                             latch_pulse,
    output logic [charger_pkg::PULSE_W-1:0]  pulse_count
);
    import charger_pkg::*;

    logic                 ctrl_prev_q;
    logic [CNT_W-1:0]     low_cnt_q;
    logic [PULSE_W-1:0]   count_q;

    always_ff @(posedge clk) begin
        if (rst || !listen) begin
            ctrl_prev_q <= 1'b0;
        end else begin
            ctrl_prev_q <= ctrl_pin;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || !listen || latch_pulse) begin
            count_q <= '0;
        end else if (ctrl_pin && !ctrl_prev_q && count_q != 5'h1f) begin
            count_q <= count_q + 5'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || !listen || ctrl_pin) begin
            low_cnt_q <= '0;
        end else if (low_cnt_q != CNT_W'(LATCH_CYC)) begin
            low_cnt_q <= low_cnt_q + 21'h000001;
        end
    end

    assign latch_pulse = listen && !ctrl_pin && count_q != '0 &&
                         low_cnt_q == CNT_W'(LATCH_CYC - 1);
    assign pulse_count = count_q;

    chk_count_clear: assert property (@(posedge clk) disable iff (rst)
        latch_pulse |=> count_q == '0)
        else $error("pulse counter not cleared after decode");
endmodule

/* File: dv/host_model.sv */
// Host model for the control pin of the charger control logic.
// Assumes one clock; the pin changes a fixed 2 ns after each rising edge.
`timescale 1ns/1ns
module host_model (
    // Clock
    input  wire logic clk,
    // Control pin
    output logic      ctrl_pin
);
    import charger_pkg::*;

    // Held a little above the minimum so that deglitch rounding never bites.
    localparam int unsigned PULSE_CYC = 1500;

    initial ctrl_pin = 1'b1;

    task automatic hold(input logic lvl, input int unsigned cyc);
        @(posedge clk);
        #2 ctrl_pin = lvl;
        if (cyc > 1) repeat (cyc - 1) @(posedge clk);
    endtask

    task automatic pulses(input int unsigned n);
        int unsigned m;
        m = (n > PULSE_MAX) ? PULSE_MAX : n;
        for (int unsigned i = 0; i < m; i++) begin
            hold(1'b1, PULSE_CYC);
            hold(1'b0, PULSE_CYC);
        end
    endtask
endmodule

/* File: dv/test_charger_pulse_control_fsm.sv */
// Self-checking testbench for the charger control logic.
// Assumes a pull-up on the status pin and a host model on the control pin.
`timescale 1ns/1ns
module test_charger_pulse_control_fsm;
    import charger_pkg::*;

    // Ceiling on the run; the fixed wait window dominates its length.
    localparam int unsigned LIMIT_CYC = 1200000;

    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        uvlo_ok = 1'b0;
    logic        ovp = 1'b0;
    logic        bat_pre = 1'b0;
    logic        bat_ovch = 1'b0;
    logic        bat_rch = 1'b0;
    logic        ts_ok = 1'b1;
    logic        ext_low = 1'b0;
    logic        ctrl_pin;
    logic        status_pin_in;
    logic        st_out;
    logic        st_oe_n;
    logic        aux_en;
    logic        chg_en;
    logic        pre_mode;
    logic        float_reg;
    logic        ts_en;
    logic [3:0]  limit;
    int unsigned cyc = 0;
    int unsigned error_cnt = 0;
    int unsigned tests_run = 0;
    int unsigned start;
    int unsigned cnt_tab [10] = '{3, 4, 5, 6, 7, 8, 9, 10, 11, 12};
    logic [3:0]  lim_tab [10] = '{LIMIT_DEFAULT, LIMIT_93MA, LIMIT_187MA,
                                  LIMIT_280MA, LIMIT_374MA, LIMIT_467MA,
                                  LIMIT_654MA, LIMIT_794MA, LIMIT_935MA,
                                  LIMIT_935MA};

    always #20 clk = ~clk;

    // A held-low status pin wins over the pull-up and the device.
    assign status_pin_in = ext_low ? 1'b0 : (st_oe_n ? 1'b1 : st_out);

    charger_ctrl i_charger_ctrl (
        .clk                 (clk),
        .rst                 (rst),
        .in_above_uvlo       (uvlo_ok),
        .in_above_ovp        (ovp),
        .bat_above_precharge (bat_pre),
        .bat_at_overcharge   (bat_ovch),
        .bat_below_recharge  (bat_rch),
        .ts_in_window        (ts_ok),
        .ctrl_pin            (ctrl_pin),
        .status_pin_in       (status_pin_in),
        .charge_status_out   (st_out),
        .charge_status_oe_n  (st_oe_n),
        .aux_regulator_en    (aux_en),
        .charge_en           (chg_en),
        .precharge_mode      (pre_mode),
        .float_regulation    (float_reg),
        .thermistor_sense_en (ts_en),
        .input_limit_sel     (limit)
    );

    host_model i_host_model (
        .clk      (clk),
        .ctrl_pin (ctrl_pin)
    );

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == LIMIT_CYC) begin
            error_cnt++;
            conclude();
        end
    end

    task automatic check(input logic [3:0] seen, input logic [3:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    task automatic tick(input int unsigned n);
        repeat (n) @(posedge clk);
        #2;
    endtask

    task automatic t_reset();
        tick(12);
        rst = 1'b0;
        tick(2);
        check(limit, LIMIT_DEFAULT);
        check(st_oe_n, 1'b1);
        check(chg_en, 1'b0);
        check(aux_en, 1'b0);
    endtask

    task automatic t_sense();
        ext_low = 1'b1;
        tick(4);
        check(ts_en, 1'b0);
        ext_low = 1'b0;
        tick(4);
        check(ts_en, 1'b1);
    endtask

    task automatic t_lockout();
        i_host_model.hold(1'b0, CTRL_DGL_CYC + 200);
        tick(0);
        check(chg_en, 1'b0);
        check(st_oe_n, 1'b1);
        check(aux_en, 1'b0);
        i_host_model.hold(1'b1, 4);
        tick(1);
    endtask

    task automatic t_overvoltage();
        uvlo_ok = 1'b1;
        tick(2);
        check(aux_en, 1'b1);
        ovp = 1'b1;
        tick(OVP_DGL_CYC - 200);
        check(aux_en, 1'b1);
        ovp = 1'b0;
        tick(4);
        ovp = 1'b1;
        tick(OVP_DGL_CYC + 20);
        check(aux_en, 1'b0);
        check(chg_en, 1'b0);
        ovp = 1'b0;
        tick(5);
        check(aux_en, 1'b1);
    endtask

    task automatic t_program();
        start = cyc;
        i_host_model.hold(1'b0, CTRL_DGL_CYC + 100);
        for (int i = 0; i < 10; i++) begin
            i_host_model.pulses(cnt_tab[i]);
            i_host_model.hold(1'b0, LATCH_CYC + 5);
            tick(1);
            check(limit, lim_tab[i]);
        end
    endtask

    task automatic t_stages();
        while (cyc < start + CTRL_DGL_CYC + WAIT_CYC + 20) @(posedge clk);
        #2;
        check(pre_mode, 1'b1);
        check(chg_en, 1'b1);
        check(st_oe_n, 1'b0);
        bat_pre = 1'b1;
        tick(4);
        check(pre_mode, 1'b0);
        check(chg_en, 1'b1);
        bat_ovch = 1'b1;
        tick(4);
        check(st_oe_n, 1'b1);
        check(float_reg, 1'b1);
        check(chg_en, 1'b1);
        bat_ovch = 1'b0;
        bat_rch = 1'b1;
        tick(4);
        check(st_oe_n, 1'b0);
        check(float_reg, 1'b0);
        check(chg_en, 1'b1);
        bat_rch = 1'b0;
        ts_ok = 1'b0;
        tick(4);
        check(chg_en, 1'b0);
        check(st_oe_n, 1'b0);
        ts_ok = 1'b1;
        tick(4);
        check(chg_en, 1'b1);
        check(limit, LIMIT_935MA);
    endtask

    task automatic t_disable();
        i_host_model.hold(1'b1, LATCH_CYC + 20);
        tick(1);
        check(chg_en, 1'b0);
        check(st_oe_n, 1'b1);
        check(aux_en, 1'b1);
    endtask

    initial begin
        t_reset();
        t_sense();
        t_lockout();
        t_overvoltage();
        t_program();
        t_stages();
        t_disable();
        conclude();
    end
endmodule
